/* File: brk_pkg.sv */
/*
 * Shared constants and carriers for the breakpoint, single-step and monitor-entry logic.
 * Assumes a 32-bit processor bus with 16-bit instruction words and long-aligned fetches.
 */
package brk_pkg;

    localparam logic [15:0] BKPT_OPCODE       = 16'h484f;
    localparam logic [15:0] FRAME_FORMAT_WORD = 16'h007c;
    localparam logic [31:0] TRACE_VECTOR_OFS  = 32'h0000_0024;
    localparam logic [2:0]  BREAK_LEVEL       = 3'h7;
    localparam logic [2:0]  NO_LEVEL          = 3'h0;
    localparam logic [15:0] TRACE_MASK        = 16'hc000;
    localparam logic [15:0] PSW_RESET         = 16'h2700;
    localparam logic [15:0] FRAME_RESET       = 16'h0000;
    localparam logic [31:0] IACK_DATA         = 32'h0000_00ff;
    localparam logic [31:0] DATA_RESET        = 32'h0000_0000;
    localparam int          HW_SLOTS_DEFAULT  = 8;

    typedef enum logic [1:0] {
        CYC_NORMAL,
        CYC_INT_ACK,
        CYC_BKPT_ACK
    } cycle_kind_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        fetch;
        cycle_kind_e kind;
        logic [31:0] addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } bus_rsp_s;

endpackage : brk_pkg

/* File: bp_hw_table.sv */
/*
 * Table of breakpoint addresses served by opcode substitution on instruction fetch.
 * Assumes lookups come from long-aligned fetches; each slot holds one word address.
 */
`timescale 1ns/1ns
module bp_hw_table #(
    parameter int SLOTS = brk_pkg::HW_SLOTS_DEFAULT
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        load_i,
    input  wire logic [31:0] load_addr_i,
    input  wire logic        clear_i,
    input  wire logic [31:0] look_addr_i,
    output logic             hit_hi_o,
    output logic             hit_lo_o,
    output logic             full_o
);
    localparam int IDX_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;

    generate
        if (SLOTS < 1 || SLOTS > 64) begin : g_bad_slots
            $error("bp_hw_table: SLOTS must lie in 1..64");
        end
    endgenerate

    logic [SLOTS-1:0] valid_reg;
    logic [30:0]      addr_reg [SLOTS];
    logic [SLOTS-1:0] hit_hi_v;
    logic [SLOTS-1:0] hit_lo_v;
    logic [IDX_W-1:0] free_idx;
    logic             found;

    // Lowest free slot wins; a full table silently drops the load
    always_comb begin
        free_idx = '0;
        found    = 1'b0;
        for (int i = 0; i < SLOTS; i++) begin
            if (!valid_reg[i] && !found) begin
                free_idx = IDX_W'(i);
                found    = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            assign hit_hi_v[g] = valid_reg[g] && (addr_reg[g] == {look_addr_i[31:2], 1'b0});
            assign hit_lo_v[g] = valid_reg[g] && (addr_reg[g] == {look_addr_i[31:2], 1'b1});

            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    valid_reg[g] <= 1'b0;
                    addr_reg[g]  <= '0;
                end else if (load_i && found && free_idx == IDX_W'(g)) begin
                    // A load in the clearing cycle survives, so a placement is lost only when the table was already full
                    valid_reg[g] <= 1'b1;
                    addr_reg[g]  <= load_addr_i[31:1];
                end else if (clear_i) begin
                    valid_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign hit_hi_o = |hit_hi_v;
    assign hit_lo_o = |hit_lo_v;
    assign full_o   = ~found;

endmodule : bp_hw_table

/* File: breakpoint_step_monitor_entry.sv */
/*
 * Debug entry logic between the processor bus and the target bus: software breakpoints,
 * breakpoint placement, fetch substitution, single step and level-7 break.
 * Assumes the processor holds a request until acked and idles its bus while in the monitor.
 */
// Summary of operation
// R1 - With breakpoints enabled, any executed breakpoint instruction enters the monitor.
// R2 - Placing a breakpoint writes the breakpoint opcode to memory, then reads it back.
// R3 - Unwritable locations get the breakpoint opcode substituted on fetch by hardware.
// R4 - Users should place breakpoints only on an instruction's first word.
// R5 - Breakpoint acknowledge starts monitor entry; stacking proceeds as for a break.
// R6 - The breakpoint-acknowledge cycle is shown to the target bus.
// R7 - The breakpoint-acknowledge cycle is terminated here at once, target ignored.
// R8 - The target must not add wait states to breakpoint acknowledge.
// R9 - A step returns to the monitor after exactly one instruction.
// R10 - Step sets the trace bits, exits normally, then forces a break.
// R11 - Trace vector fetch, then handler prefetch, precede the forced break.
// R12 - Breaks use level 7; their interrupt acknowledge is hidden from target.
// R13 - Monitor exit always uses the four-word frame with fixed format word.
// R14 - With breakpoints disabled, no entry from acknowledge and no substitution.
`timescale 1ns/1ns
module breakpoint_step_monitor_entry #(
    parameter int HW_SLOTS = brk_pkg::HW_SLOTS_DEFAULT
) (
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    input  wire logic             breakpoint_enable_command_i,
    input  wire logic             bp_set_i,
    input  wire logic [31:0]      bp_addr_i,
    input  wire logic             bp_clear_all_i,
    input  wire logic             run_i,
    input  wire logic             step_i,
    input  wire logic             break_i,
    input  wire logic [15:0]      psw_i,
    input  wire logic [31:0]      vector_base_i,
    input  wire brk_pkg::bus_req_s cpu_req_i,
    output brk_pkg::bus_rsp_s     cpu_rsp_o,
    output logic [2:0]            cpu_ipl_o,
    output brk_pkg::bus_req_s     tgt_req_o,
    input  wire brk_pkg::bus_rsp_s tgt_rsp_i,
    output logic                  in_monitor_o,
    output logic                  monitor_entry_o,
    output logic                  monitor_exit_o,
    output logic [15:0]           processor_status_word_o,
    output logic [15:0]           exit_frame_format_o,
    output logic                  bp_done_o,
    output logic                  bp_in_hardware_o,
    output logic                  bp_table_full_o
);
    typedef enum logic [2:0] {
        ST_RUN, ST_MONITOR, ST_STEP_EXEC, ST_STEP_TRACE, ST_BREAK
    } mon_state_e;
    typedef enum logic [1:0] {BP_IDLE, BP_WRITE, BP_READ, BP_CHECK} place_state_e;

    mon_state_e        state_reg, state_next;
    place_state_e      place_reg, place_next;
    logic              done_reg;
    logic [31:0]       rdata_reg;
    logic              entry_reg, exit_reg;
    logic [15:0]       psw_reg, frame_reg;
    logic [31:0]       bp_addr_reg;
    logic [15:0]       readback_reg;
    logic              bp_done_reg, bp_hw_reg;

    wire logic         in_mon      = (state_reg == ST_MONITOR);
    wire logic         cpu_cycle   = cpu_req_i.valid & ~done_reg & ~in_mon;
    wire logic         is_bkpt     = (cpu_req_i.kind == brk_pkg::CYC_BKPT_ACK);
    wire logic         is_iack     = (cpu_req_i.kind == brk_pkg::CYC_INT_ACK);
    wire logic         bkpt_taken  = cpu_cycle & is_bkpt & breakpoint_enable_command_i;  // R1 R14
    wire logic         iack_hidden = cpu_cycle & is_iack & (state_reg == ST_BREAK);      // R12
    wire logic         own_term    = bkpt_taken | iack_hidden;
    wire logic         ack_now     = own_term | (cpu_cycle & tgt_rsp_i.ack);             // R7 R8
    wire logic         place_idle  = (place_reg == BP_IDLE);
    wire logic         place_bus   = (place_reg == BP_WRITE) | (place_reg == BP_READ);
    wire logic         hit_hi, hit_lo;
    wire logic         sub_en      = breakpoint_enable_command_i & cpu_req_i.fetch;      // R3 R14
    wire logic [31:0]  trace_addr  = vector_base_i + brk_pkg::TRACE_VECTOR_OFS;
    wire logic         trace_vec_rd = ack_now & ~cpu_req_i.write & ~cpu_req_i.fetch
                                      & (cpu_req_i.addr == trace_addr);                   // R11
    wire logic         fetch_done  = ack_now & cpu_req_i.fetch;
    wire logic [31:0]  rdata_sub;
    wire logic [31:0]  cpu_data;
    wire brk_pkg::bus_req_s place_req;
    wire brk_pkg::bus_req_s fwd_req;
    wire logic [15:0]  read_word;
    wire logic         bp_mismatch = (readback_reg != brk_pkg::BKPT_OPCODE);

    // Substitution swaps just the word of the long fetch that holds the breakpoint
    assign rdata_sub = {(sub_en & hit_hi) ? brk_pkg::BKPT_OPCODE : tgt_rsp_i.rdata[31:16],
                        (sub_en & hit_lo) ? brk_pkg::BKPT_OPCODE : tgt_rsp_i.rdata[15:0]}; // R3
    assign cpu_data  = iack_hidden ? brk_pkg::IACK_DATA : rdata_sub;

    // Breakpoint placement owns the target bus only while the processor sits in the monitor
    assign place_req = '{valid: place_bus, write: (place_reg == BP_WRITE), fetch: 1'b0,
                         kind: brk_pkg::CYC_NORMAL, addr: bp_addr_reg,
                         wdata: brk_pkg::BKPT_OPCODE};                                    // R2
    // Target still sees breakpoint acknowledge; the hidden level-7 acknowledge never shows
    assign fwd_req   = '{valid: cpu_cycle & ~iack_hidden, write: cpu_req_i.write,
                         fetch: cpu_req_i.fetch, kind: cpu_req_i.kind,
                         addr: cpu_req_i.addr, wdata: cpu_req_i.wdata};                   // R6 R12
    assign tgt_req_o = in_mon ? place_req : fwd_req;
    assign read_word = bp_addr_reg[1] ? tgt_rsp_i.rdata[15:0] : tgt_rsp_i.rdata[31:16];

    bp_hw_table #(
        .SLOTS      (HW_SLOTS)
    ) u_table (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .load_i     ((place_reg == BP_CHECK) & bp_mismatch),                             // R3
        .load_addr_i(bp_addr_reg),
        .clear_i    (bp_clear_all_i),
        .look_addr_i(cpu_req_i.addr),
        .hit_hi_o   (hit_hi),
        .hit_lo_o   (hit_lo),
        .full_o     (bp_table_full_o)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (bkpt_taken) begin
                    state_next = ST_MONITOR;                                             // R1 R5
                end else if (break_i) begin
                    state_next = ST_BREAK;                                               // R12
                end
            end
            ST_MONITOR: begin
                if (step_i && place_idle) begin
                    state_next = ST_STEP_EXEC;                                           // R10
                end else if (run_i && place_idle) begin
                    state_next = ST_RUN;
                end
            end
            ST_STEP_EXEC: begin
                if (bkpt_taken) begin
                    state_next = ST_MONITOR;
                end else if (trace_vec_rd) begin
                    state_next = ST_STEP_TRACE;                                          // R11
                end
            end
            ST_STEP_TRACE: begin
                if (bkpt_taken) begin
                    state_next = ST_MONITOR;
                end else if (fetch_done) begin
                    state_next = ST_BREAK;                                               // R9 R11
                end
            end
            ST_BREAK: begin
                if (iack_hidden || bkpt_taken) begin
                    state_next = ST_MONITOR;
                end
            end
            default: state_next = ST_MONITOR;
        endcase
    end

    always_comb begin
        place_next = place_reg;
        unique case (place_reg)
            BP_IDLE:  if (bp_set_i && in_mon) place_next = BP_WRITE;                      // R2
            BP_WRITE: if (tgt_rsp_i.ack) place_next = BP_READ;                            // R2
            BP_READ:  if (tgt_rsp_i.ack) place_next = BP_CHECK;
            BP_CHECK: place_next = BP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_RUN;
            place_reg <= BP_IDLE;
            done_reg  <= 1'b0;
            rdata_reg <= brk_pkg::DATA_RESET;
            entry_reg <= 1'b0;
            exit_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            place_reg <= place_next;
            done_reg  <= ack_now;
            rdata_reg <= ack_now ? cpu_data : rdata_reg;
            entry_reg <= ~in_mon & (state_next == ST_MONITOR);
            exit_reg  <= in_mon & (state_next != ST_MONITOR);
        end
    end

    // Exit frame and status word are loaded together, so they match on the exit pulse
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            psw_reg   <= brk_pkg::PSW_RESET;
            frame_reg <= brk_pkg::FRAME_RESET;
        end else if (in_mon && state_next != ST_MONITOR) begin
            psw_reg   <= (state_next == ST_STEP_EXEC) ? (psw_i | brk_pkg::TRACE_MASK)
                                                      : psw_i;                            // R10
            frame_reg <= brk_pkg::FRAME_FORMAT_WORD;                                      // R13
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bp_addr_reg  <= '0;
            readback_reg <= '0;
            bp_done_reg  <= 1'b0;
            bp_hw_reg    <= 1'b0;
        end else begin
            bp_addr_reg  <= (place_idle && place_next == BP_WRITE) ? bp_addr_i : bp_addr_reg;
            readback_reg <= (place_reg == BP_READ && tgt_rsp_i.ack) ? read_word : readback_reg;
            bp_done_reg  <= (place_reg == BP_CHECK);
            bp_hw_reg    <= (place_reg == BP_CHECK) ? bp_mismatch : bp_hw_reg;            // R3
        end
    end

    assign cpu_rsp_o               = '{ack: done_reg, rdata: rdata_reg};
    assign cpu_ipl_o               = (state_reg == ST_BREAK) ? brk_pkg::BREAK_LEVEL
                                                             : brk_pkg::NO_LEVEL;        // R12
    assign in_monitor_o            = in_mon;
    assign monitor_entry_o         = entry_reg;
    assign monitor_exit_o          = exit_reg;
    assign processor_status_word_o = psw_reg;
    assign exit_frame_format_o     = frame_reg;
    assign bp_done_o               = bp_done_reg;
    assign bp_in_hardware_o        = bp_hw_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_place_write;
        tgt_req_o.valid && tgt_req_o.write && tgt_req_o.wdata == brk_pkg::BKPT_OPCODE;
    endsequence
    sequence s_place_read;
        tgt_req_o.valid && !tgt_req_o.write && tgt_req_o.addr == bp_addr_reg;
    endsequence
    sequence s_trace_then_fetch;
        (state_reg == ST_STEP_EXEC && trace_vec_rd)
            ##[1:64] (state_reg == ST_STEP_TRACE && fetch_done);
    endsequence

    a_bkpt_ack_term: // R7
    assert property (bkpt_taken |=> cpu_rsp_o.ack) else $error("breakpoint ack not ended");
    a_bkpt_ack_shown: // R6
    assert property (bkpt_taken |-> tgt_req_o.valid && tgt_req_o.kind == brk_pkg::CYC_BKPT_ACK)
        else $error("breakpoint ack not shown to target");
    a_bkpt_entry: // R1
    assert property (bkpt_taken |=> monitor_entry_o && in_monitor_o) else $error("no entry");
    a_disabled_quiet: // R14
    assert property (cpu_cycle && is_bkpt && !breakpoint_enable_command_i && state_reg == ST_RUN
                     |=> !in_monitor_o && !cpu_rsp_o.ack == !$past(tgt_rsp_i.ack))
        else $error("disabled breakpoint acted on");
    a_iack_hidden: // R12
    assert property (state_reg == ST_BREAK && cpu_cycle && is_iack
                     |-> !tgt_req_o.valid && cpu_ipl_o == 3'h7 ##1 cpu_rsp_o.ack)
        else $error("break ack leaked to target");
    a_step_trace_bits: // R10
    assert property (in_mon && step_i && place_idle
                     |=> monitor_exit_o && processor_status_word_o[15:14] == 2'h3)
        else $error("step did not set trace bits");
    a_exit_frame: // R13
    assert property (monitor_exit_o |-> exit_frame_format_o == 16'h007c)
        else $error("wrong exit frame word");
    a_step_break: // R9
    assert property (s_trace_then_fetch |=> cpu_ipl_o == 3'h7) else $error("step break late");
    a_place_order: // R2
    assert property (place_idle && bp_set_i && in_mon |=> s_place_write ##[1:64] s_place_read)
        else $error("breakpoint write then readback missing");
    a_fetch_subst: // R3
    assert property (sub_en && hit_hi && ack_now && !iack_hidden
                     |=> cpu_rsp_o.rdata[31:16] == 16'h484f)
        else $error("opcode not substituted");

endmodule : breakpoint_step_monitor_entry

/* File: tgt_mem_model.sv */
/*
 * Behavioural target bus: 128 words of memory answering requests after a set latency.
 * Assumes long-aligned reads; addresses with bit 7 set act as ROM and ignore writes.
 */
`timescale 1ns/1ns
module tgt_mem_model (
    input  wire logic              clk_sys_i,
    input  wire logic              sys_rst_i,
    input  wire brk_pkg::bus_req_s req_i,
    input  wire logic [3:0]        lat_i,
    input  wire logic              fast_bkpt_i,
    output brk_pkg::bus_rsp_s      rsp_o
);
    logic [15:0] mem_reg [0:127];
    logic [3:0]  cnt_reg;
    logic [31:0] rd;
    logic        bkpt_now;

    assign rd = {mem_reg[{req_i.addr[7:2], 1'b0}], mem_reg[{req_i.addr[7:2], 1'b1}]};
    // A target that stalls here would desynchronise from the emulator
    assign bkpt_now = fast_bkpt_i && (req_i.kind == brk_pkg::CYC_BKPT_ACK);

    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 128; i++) mem_reg[i] <= 16'h4e71 ^ 16'(i);
            cnt_reg <= 4'h0;
            rsp_o   <= '0;
        end else if (rsp_o.ack) begin
            rsp_o.ack   <= 1'b0;
            rsp_o.rdata <= ~rsp_o.rdata;
            cnt_reg     <= 4'h0;
        end else if (req_i.valid && (cnt_reg == lat_i || bkpt_now)) begin
            rsp_o.ack   <= 1'b1;
            rsp_o.rdata <= rd;
            if (req_i.write && !req_i.addr[7]) mem_reg[req_i.addr[7:1]] <= req_i.wdata;
        end else begin
            // Data not being answered keeps changing so stale values never match
            rsp_o.rdata <= ~rsp_o.rdata;
            cnt_reg     <= req_i.valid ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule : tgt_mem_model

/* File: testbench.sv */
/*
 * Self-checking bench for the breakpoint, step and monitor entry logic.
 * Assumes the target bus model beside it; the bench plays the processor.
 */
`timescale 1ns/1ns
module testbench;
    logic              clk_sys_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              en = 1'b1, bp_set = 1'b0, clr = 1'b0, run = 1'b0, stp = 1'b0, brk = 1'b0;
    logic [31:0]       bp_addr = 32'h0, vbase = 32'h40, d;
    logic [15:0]       psw = 16'h2000, rom_word;
    brk_pkg::bus_req_s req = '0, tgt_req;
    brk_pkg::bus_rsp_s cpu_rsp, tgt_rsp;
    logic [2:0]        ipl;
    logic              in_mon, ent_o, ext_o, done_o, in_hw, full;
    logic [15:0]       psw_o, frame;
    logic [3:0]        lat = 4'h1;
    logic              fast = 1'b1, ent, ext, tv, done;
    int                miscompares = 0, n_compared = 0, n;

    breakpoint_step_monitor_entry breakpoint_step_monitor_entry_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .breakpoint_enable_command_i(en),
        .bp_set_i(bp_set), .bp_addr_i(bp_addr), .bp_clear_all_i(clr), .run_i(run),
        .step_i(stp), .break_i(brk), .psw_i(psw), .vector_base_i(vbase), .cpu_req_i(req),
        .cpu_rsp_o(cpu_rsp), .cpu_ipl_o(ipl), .tgt_req_o(tgt_req), .tgt_rsp_i(tgt_rsp),
        .in_monitor_o(in_mon), .monitor_entry_o(ent_o), .monitor_exit_o(ext_o),
        .processor_status_word_o(psw_o), .exit_frame_format_o(frame), .bp_done_o(done_o),
        .bp_in_hardware_o(in_hw), .bp_table_full_o(full));
    tgt_mem_model tgt_mem_model_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .req_i(tgt_req), .lat_i(lat), .fast_bkpt_i(fast), .rsp_o(tgt_rsp));

    initial forever #5 clk_sys_i = ~clk_sys_i;
    // Pulses are latched here so a check never depends on the exact cycle of a level
    always @(posedge clk_sys_i) begin
        if (ent_o === 1'b1) ent = 1'b1;
        if (ext_o === 1'b1) ext = 1'b1;
        if (tgt_req.valid === 1'b1) tv = 1'b1;
        if (done_o === 1'b1) done = 1'b1;
    end

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    // Processor bus cycle: request held until the edge where ack is sampled
    task automatic cyc(input brk_pkg::cycle_kind_e k, input logic f, input logic [31:0] a);
        tick();
        ent = 1'b0;
        tv  = 1'b0;
        req = '{valid: 1'b1, write: 1'b0, fetch: f, kind: k, addr: a, wdata: 16'h0};
        n   = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (cpu_rsp.ack !== 1'b1 && n < 40);
        chk("bus cycle ack", 1'b1, cpu_rsp.ack);
        d = cpu_rsp.rdata;
        #1 req.valid = 1'b0;
    endtask : cyc
    task automatic t_break();
        brk = 1'b1;
        tick();
        brk = 1'b0;
        tick();
        tick();
        chk("break level", brk_pkg::BREAK_LEVEL, ipl);
        cyc(brk_pkg::CYC_INT_ACK, 1'b0, 32'hffff_fffc);
        chk("iack hidden", 1'b0, tv);
        chk("iack cycles", 2, n);
        chk("iack data", brk_pkg::IACK_DATA, d);
        tick();
        chk("break entry", 1'b1, ent & in_mon);
        $display("test break finished");
    endtask : t_break
    task automatic t_place(input logic [31:0] a, input logic rom);
        done    = 1'b0;
        bp_addr = a;
        bp_set  = 1'b1;
        tick();
        bp_set = 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) tick();
        tick();
        chk("place done", 1'b1, done);
        chk("place method", rom, in_hw);
        chk("table not full", 1'b0, full);
        if (!rom) chk("in memory", brk_pkg::BKPT_OPCODE, tgt_mem_model_i.mem_reg[a[7:1]]);
        $display("test place finished");
    endtask : t_place
    task automatic t_exit(input logic s);
        ext = 1'b0;
        run = !s;
        stp = s;
        tick();
        run = 1'b0;
        stp = 1'b0;
        tick();
        chk("exit pulse", 1'b1, ext & !in_mon);
        chk("exit frame", brk_pkg::FRAME_FORMAT_WORD, frame);
        chk("exit status", s ? (psw | brk_pkg::TRACE_MASK) : psw, psw_o);
    endtask : t_exit
    task automatic t_bkpt();
        t_exit(1'b0);
        cyc(brk_pkg::CYC_NORMAL, 1'b1, 32'h88);
        chk("rom fetch substituted", brk_pkg::BKPT_OPCODE, d[31:16]);
        chk("rom low word substituted", brk_pkg::BKPT_OPCODE, d[15:0]);
        cyc(brk_pkg::CYC_NORMAL, 1'b1, 32'h08);
        chk("ram fetch placed", brk_pkg::BKPT_OPCODE, d[31:16]);
        fast = 1'b0;
        lat  = 4'h6;
        cyc(brk_pkg::CYC_BKPT_ACK, 1'b0, 32'h0);
        chk("bkpt ack cycles", 2, n);
        chk("bkpt ack visible", 1'b1, tv);
        tick();
        chk("bkpt entry", 1'b1, ent & in_mon);
        repeat (8) tick();
        fast = 1'b1;
        lat  = 4'h1;
        $display("test breakpoint entry finished");
    endtask : t_bkpt
    task automatic t_disabled();
        en = 1'b0;
        t_exit(1'b0);
        cyc(brk_pkg::CYC_NORMAL, 1'b1, 32'h88);
        chk("no substitution", rom_word, d[31:16]);
        chk("no low substitution", rom_word ^ 16'h0001, d[15:0]);
        cyc(brk_pkg::CYC_BKPT_ACK, 1'b0, 32'h0);
        chk("disabled ack to target", 1'b1, tv);
        tick();
        chk("no bkpt entry", 1'b0, in_mon | ent);
        en = 1'b1;
        t_break();
        clr = 1'b1;
        tick();
        clr = 1'b0;
        t_exit(1'b0);
        cyc(brk_pkg::CYC_NORMAL, 1'b1, 32'h88);
        chk("table cleared", rom_word, d[31:16]);
        chk("table low cleared", rom_word ^ 16'h0001, d[15:0]);
        t_break();
        $display("test disabled finished");
    endtask : t_disabled
    task automatic t_step();
        t_exit(1'b1);
        cyc(brk_pkg::CYC_NORMAL, 1'b0, vbase + brk_pkg::TRACE_VECTOR_OFS);
        tick();
        chk("no break before prefetch", brk_pkg::NO_LEVEL, ipl);
        cyc(brk_pkg::CYC_NORMAL, 1'b1, 32'h10);
        for (int i = 0; i < 4 && ipl !== brk_pkg::BREAK_LEVEL; i++) tick();
        chk("step break level", brk_pkg::BREAK_LEVEL, ipl);
        cyc(brk_pkg::CYC_INT_ACK, 1'b0, 32'hffff_fffc);
        tick();
        chk("step back in monitor", 1'b1, in_mon & ent & !tv);
        $display("test step finished");
    endtask : t_step

    task automatic t_reset();
        chk("reset monitor", 1'b0, in_mon);
        chk("reset level", brk_pkg::NO_LEVEL, ipl);
        chk("reset status", brk_pkg::PSW_RESET, psw_o);
        $display("test reset finished");
    endtask : t_reset

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        rom_word = 16'h4e71 ^ 16'h0044;
        repeat (8) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        tick();
        t_reset();
        t_break();
        t_place(32'h08, 1'b0);
        t_place(32'h88, 1'b1);
        t_place(32'h8a, 1'b1);
        t_bkpt();
        t_disabled();
        t_step();
        print_verdict();
    end
endmodule : testbench
